// ==== shared/mist_pkg.sv ====
`default_nettype none
package mist_pkg;

  // ****************************************
  // field encodings
  // ****************************************
  localparam logic [1:0] TACHO_OFF     = 2'h0;
  localparam logic [1:0] TACHO_RISE    = 2'h1;
  localparam logic [1:0] TACHO_FALL    = 2'h2;
  localparam logic [1:0] TACHO_BOTH    = 2'h3;
  localparam logic [1:0] SEL_ENCODER   = 2'h3;
  localparam logic [1:0] INPUT_SEL_RST = 2'h0;
  localparam logic [2:0] SYNC_RST      = 3'h0;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [5:0] {
    MIST_MODE_NONE       = 6'h01,
    MIST_MODE_POSITION   = 6'h02,
    MIST_MODE_SENSORLESS = 6'h04,
    MIST_MODE_TACHO      = 6'h08,
    MIST_MODE_ENCODER    = 6'h10,
    MIST_MODE_PORTS      = 6'h20
  } mist_mode_type;

  // per-pin role
  typedef struct packed {
    logic analog;      // comparator input, digital read disabled
    logic digital;     // digital sensor input, port read kept
    logic port;        // plain port pin
    logic offstate;    // reserved, not selected (sensorless)
    logic grounded;    // offstate and discharged to ground
  } mist_pin_type;

  typedef struct packed {
    logic sensor_mode_select;
    logic [1:0] tacho_edge_select;
    logic [1:0] input_select;
    logic motor_pin_release;
    logic offstate_discharge_select;
  } mist_cfg_type;

endpackage
`default_nettype wire

// ==== design/mist_input_stage.sv ====
// Behaviour
// - sensor mode: one input, both edges
// - sensorless: unselected pins reserved, selected one analog
// - unselected sensorless pins hi-z or ground
// - nonzero tacho field with release: tacho edge selection, inactive without release
// - encoder: both edges, a/b digital
// - release tacho: selected digital, comparator off
// - sensor with select 11: ports, comparator off
// - release, field 00, select not 11: analog, comparator on
// - analog pin blocks digital port read
// - digital sensor pin stays port readable
// - select preloaded, direct access loads now
// - direction: sample a on b falling
`timescale 1ns/1ns
`default_nettype none
module mist_input_stage (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic                   clock_enable,
  input  wire mist_pkg::mist_cfg_type cfg,
  input  wire logic                   direct_access,
  input  wire logic                   commutation_event,
  input  wire logic                   motor_input_a,
  input  wire logic                   motor_input_b,
  input  wire logic                   motor_input_c,
  output logic [1:0]                  input_select_active,
  output mist_pkg::mist_mode_type     mode,
  output logic                        phase_comparator_on,
  output mist_pkg::mist_pin_type      pin_a,
  output mist_pkg::mist_pin_type      pin_b,
  output mist_pkg::mist_pin_type      pin_c,
  output logic [2:0]                  port_read_enable,
  output logic [2:0]                  port_pin_level,
  output logic                        sensor_event,
  output logic                        encoder_direction
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d, prev_q, prev_d;
  assign pin_raw = {motor_input_c, motor_input_b, motor_input_a};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_comb begin
        s1_d[g]   = pin_raw[g];
        s2_d[g]   = s1_q[g];
        s3_d[g]   = s2_q[g];
        // a change counts once stages two and three agree
        lvl_d[g]  = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
        prev_d[g] = lvl_q[g];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q   <= mist_pkg::SYNC_RST;
      s2_q   <= mist_pkg::SYNC_RST;
      s3_q   <= mist_pkg::SYNC_RST;
      lvl_q  <= mist_pkg::SYNC_RST;
      prev_q <= mist_pkg::SYNC_RST;
    end else if (clock_enable) begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      lvl_q  <= lvl_d;
      prev_q <= prev_d;
    end
  end

  // ****************************************
  // input select preload
  // ****************************************
  logic [1:0] sel_q, sel_d;
  always_comb begin
    sel_d = sel_q;
    if (direct_access || commutation_event) begin
      sel_d = cfg.input_select;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_q <= mist_pkg::INPUT_SEL_RST;
    end else if (clock_enable) begin
      sel_q <= sel_d;
    end
  end
  assign input_select_active = sel_q;

  // ****************************************
  // mode decode
  // ****************************************
  logic tacho_nz, sel_enc;
  assign tacho_nz = (cfg.tacho_edge_select != mist_pkg::TACHO_OFF);
  assign sel_enc  = (sel_q == mist_pkg::SEL_ENCODER);

  mist_pkg::mist_mode_type mode_c;
  always_comb begin
    mode_c = mist_pkg::MIST_MODE_NONE;
    if (tacho_nz) begin
      if (cfg.motor_pin_release) begin
        mode_c = sel_enc ? mist_pkg::MIST_MODE_ENCODER : mist_pkg::MIST_MODE_TACHO;
      end
    end else if (cfg.motor_pin_release) begin
      mode_c = sel_enc ? mist_pkg::MIST_MODE_PORTS : mist_pkg::MIST_MODE_POSITION;
    end else if (cfg.sensor_mode_select) begin
      mode_c = sel_enc ? mist_pkg::MIST_MODE_PORTS : mist_pkg::MIST_MODE_POSITION;
    end else if (!sel_enc) begin
      mode_c = mist_pkg::MIST_MODE_SENSORLESS;
    end
  end

  // ****************************************
  // pin roles and comparator
  // ****************************************
  logic [2:0] sel_hot, analog_v, digital_v, off_v;
  assign sel_hot = sel_enc ? 3'h0 : (3'h1 << sel_q);

  always_comb begin
    analog_v  = 3'h0;
    digital_v = 3'h0;
    off_v     = 3'h0;
    case (mode_c)
      mist_pkg::MIST_MODE_POSITION:   analog_v = sel_hot;
      mist_pkg::MIST_MODE_SENSORLESS: begin
        analog_v = sel_hot;
        off_v    = ~sel_hot;
      end
      mist_pkg::MIST_MODE_TACHO:      digital_v = sel_hot;
      mist_pkg::MIST_MODE_ENCODER:    digital_v = 3'h3;
      default:                        analog_v = 3'h0;
    endcase
  end

  logic comp_c;
  assign comp_c = (analog_v != 3'h0);

  // ****************************************
  // edge detection
  // ****************************************
  logic [2:0] rise, fall;
  logic       rise_s, fall_s, ev_c;
  assign rise   = lvl_q & ~prev_q;
  assign fall   = ~lvl_q & prev_q;
  assign rise_s = |(rise & sel_hot);
  assign fall_s = |(fall & sel_hot);

  always_comb begin
    ev_c = 1'h0;
    case (mode_c)
      mist_pkg::MIST_MODE_POSITION,
      mist_pkg::MIST_MODE_SENSORLESS: ev_c = rise_s | fall_s;
      mist_pkg::MIST_MODE_TACHO: begin
        case (cfg.tacho_edge_select)
          mist_pkg::TACHO_RISE: ev_c = rise_s;
          mist_pkg::TACHO_FALL: ev_c = fall_s;
          mist_pkg::TACHO_BOTH: ev_c = rise_s | fall_s;
          default:              ev_c = 1'h0;
        endcase
      end
      mist_pkg::MIST_MODE_ENCODER:    ev_c = |(rise[1:0] | fall[1:0]);
      default:                        ev_c = 1'h0;
    endcase
  end

  // ****************************************
  // output registers
  // ****************************************
  mist_pkg::mist_mode_type mode_q;
  mist_pkg::mist_pin_type  pa_d, pb_d, pc_d, pa_q, pb_q, pc_q;
  logic       comp_q, ev_q, dir_q, dir_d;
  logic [2:0] rd_q, rd_d, lv_q, lv_d;

  always_comb begin
    pa_d = '{analog: analog_v[0], digital: digital_v[0], port: ~(analog_v[0] | digital_v[0] | off_v[0]),
             offstate: off_v[0], grounded: off_v[0] & cfg.offstate_discharge_select};
    pb_d = '{analog: analog_v[1], digital: digital_v[1], port: ~(analog_v[1] | digital_v[1] | off_v[1]),
             offstate: off_v[1], grounded: off_v[1] & cfg.offstate_discharge_select};
    pc_d = '{analog: analog_v[2], digital: digital_v[2], port: ~(analog_v[2] | digital_v[2] | off_v[2]),
             offstate: off_v[2], grounded: off_v[2] & cfg.offstate_discharge_select};
    rd_d  = ~analog_v;
    lv_d  = lvl_q & rd_d;
    dir_d = dir_q;
    if (mode_c == mist_pkg::MIST_MODE_ENCODER && fall[1]) begin
      dir_d = lvl_q[0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= mist_pkg::MIST_MODE_NONE;
      pa_q   <= '0;
      pb_q   <= '0;
      pc_q   <= '0;
      comp_q <= 1'h0;
      ev_q   <= 1'h0;
      dir_q  <= 1'h0;
      rd_q   <= 3'h0;
      lv_q   <= 3'h0;
    end else if (clock_enable) begin
      mode_q <= mode_c;
      pa_q   <= pa_d;
      pb_q   <= pb_d;
      pc_q   <= pc_d;
      comp_q <= comp_c;
      ev_q   <= ev_c;
      dir_q  <= dir_d;
      rd_q   <= rd_d;
      lv_q   <= lv_d;
    end
  end

  assign mode                = mode_q;
  assign phase_comparator_on = comp_q;
  assign pin_a               = pa_q;
  assign pin_b               = pb_q;
  assign pin_c               = pc_q;
  assign port_read_enable    = rd_q;
  assign port_pin_level      = lv_q;
  assign sensor_event        = ev_q;
  assign encoder_direction   = dir_q;

endmodule // mist_input_stage
`default_nettype wire

// ==== verification/mist_input_stage_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module mist_input_stage_monitor (
  input wire logic                    clock,
  input wire logic                    resetn,
  input wire logic                    clock_enable,
  input wire mist_pkg::mist_cfg_type  cfg,
  input wire logic                    direct_access,
  input wire logic [1:0]              input_select_active,
  input wire mist_pkg::mist_mode_type mode,
  input wire logic                    phase_comparator_on,
  input wire mist_pkg::mist_pin_type  pin_a,
  input wire mist_pkg::mist_pin_type  pin_b,
  input wire mist_pkg::mist_pin_type  pin_c,
  input wire logic [2:0]              port_read_enable,
  input wire logic [2:0]              port_pin_level,
  input wire logic                    sensor_event
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ********
  // checks
  // ********
  property p_an; pin_a.analog |-> !port_read_enable[0]; endproperty
  a_an: assert property (p_an) else $error("analog pin readable");
  property p_lv; !port_read_enable[1] |-> !port_pin_level[1]; endproperty
  a_lv: assert property (p_lv) else $error("blocked level shown");
  property p_en;
    mode == mist_pkg::MIST_MODE_ENCODER |-> pin_a.digital && pin_b.digital && !phase_comparator_on;
  endproperty
  a_en: assert property (p_en) else $error("encoder pins wrong");
  property p_pc; mode == mist_pkg::MIST_MODE_ENCODER |-> pin_c.port && !pin_c.digital; endproperty
  a_pc: assert property (p_pc) else $error("encoder pin c not port");
  property p_ta; mode == mist_pkg::MIST_MODE_TACHO |-> !phase_comparator_on && !pin_b.analog; endproperty
  a_ta: assert property (p_ta) else $error("tacho comparator on");
  property p_po; mode == mist_pkg::MIST_MODE_POSITION |-> phase_comparator_on; endproperty
  a_po: assert property (p_po) else $error("position comparator off");
  property p_na; mode == mist_pkg::MIST_MODE_NONE |-> !sensor_event && !phase_comparator_on; endproperty
  a_na: assert property (p_na) else $error("inactive mode acts");
  property p_gd; pin_b.offstate |-> pin_b.grounded == $past(cfg.offstate_discharge_select); endproperty
  a_gd: assert property (p_gd) else $error("discharge wrong");
  property p_ld; clock_enable && direct_access |=> input_select_active == $past(cfg.input_select); endproperty
  a_ld: assert property (p_ld) else $error("select not loaded");
  property p_hd; !clock_enable |=> $stable(input_select_active) && $stable(mode); endproperty
  a_hd: assert property (p_hd) else $error("frozen state moved");
  c_en: cover property (sensor_event && mode == mist_pkg::MIST_MODE_ENCODER);
  c_ta: cover property (sensor_event && mode == mist_pkg::MIST_MODE_TACHO);
  c_gd: cover property (pin_b.grounded);
endmodule // mist_input_stage_monitor
bind mist_input_stage mist_input_stage_monitor i_mon (.clock, .resetn, .clock_enable, .cfg, .direct_access,
  .input_select_active, .mode, .phase_comparator_on, .pin_a, .pin_b, .pin_c, .port_read_enable, .port_pin_level,
  .sensor_event);
`default_nettype wire

// ==== verification/mist_sensor_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mist_sensor_model (
  input  wire logic clock,
  input  wire logic step,
  input  wire logic reverse,
  output logic      motor_input_a,
  output logic      motor_input_b,
  output logic      motor_input_c
);
  logic [1:0] ph_q = 2'h0;
  // quadrature pair, c toggles every step
  always @(posedge clock) if (step) ph_q <= reverse ? ph_q - 2'h1 : ph_q + 2'h1;
  assign motor_input_a = ph_q[1];
  assign motor_input_b = ph_q[1] ^ ph_q[0];
  assign motor_input_c = ph_q[0];
endmodule // mist_sensor_model
`default_nettype wire

// ==== verification/mist_input_stage_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module mist_input_stage_test;
  typedef struct packed {
    mist_pkg::mist_cfg_type c;
    logic [5:0]             m;
    logic                   p;
    logic [2:0]             r;
    logic [4:0]             b;
    logic [7:0]             e;
  } mist_row_type;
  logic                   clock = 1'h0;
  logic                   resetn = 1'h0;
  logic                   clock_enable = 1'h1;
  mist_pkg::mist_cfg_type cfg = '0;
  logic                   direct_access = 1'h0;
  logic                   commutation_event = 1'h0;
  logic                   step = 1'h0;
  logic                   reverse = 1'h0;
  logic                   motor_input_a, motor_input_b, motor_input_c;
  logic [1:0]             input_select_active;
  mist_pkg::mist_mode_type mode;
  mist_pkg::mist_pin_type pin_a, pin_b;
  logic [2:0]             port_read_enable, port_pin_level;
  logic                   phase_comparator_on, sensor_event, encoder_direction;
  int                     err_total = 0;
  int                     n_compared = 0;
  // cfg, mode, comparator, read enables, pin b role, events in 8 steps (ff: not checked)
  // select also changed while comparator on (rows 0 to 2)
  // release/field 00 analog row is left only by a row with the same select
  mist_row_type rows [12] = '{
    '{7'h44, 6'h02, 1'h1, 3'h5, 5'h10, 8'h04}, '{7'h01, 6'h04, 1'h1, 3'h6, 5'h03, 8'hff},
    '{7'h08, 6'h04, 1'h1, 3'h3, 5'h02, 8'hff}, '{7'h0c, 6'h01, 1'h0, 3'h7, 5'h04, 8'h00},
    '{7'h4c, 6'h20, 1'h0, 3'h7, 5'h04, 8'h00}, '{7'h16, 6'h08, 1'h0, 3'h7, 5'h08, 8'h02},
    '{7'h62, 6'h08, 1'h0, 3'h7, 5'h04, 8'h02}, '{7'h3a, 6'h08, 1'h0, 3'h7, 5'h04, 8'h08},
    '{7'h1e, 6'h10, 1'h0, 3'h7, 5'h08, 8'h08}, '{7'h06, 6'h02, 1'h1, 3'h5, 5'h10, 8'h04},
    '{7'h24, 6'h01, 1'h0, 3'h7, 5'h04, 8'h00}, '{7'h0e, 6'h20, 1'h0, 3'h7, 5'h04, 8'h00}};

  mist_input_stage i_dut (.clock, .resetn, .clock_enable, .cfg, .direct_access, .commutation_event,
    .motor_input_a, .motor_input_b, .motor_input_c, .input_select_active, .mode, .phase_comparator_on,
    .pin_a, .pin_b, .pin_c(), .port_read_enable, .port_pin_level, .sensor_event, .encoder_direction);
  mist_sensor_model i_sensor (.clock, .step, .reverse, .motor_input_a, .motor_input_b, .motor_input_c);

  always #4 clock = ~clock;

  // ********
  // tasks
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_row(input mist_row_type r);
    int n;
    n = 0;
    @(posedge clock);
    cfg <= r.c;
    direct_access <= 1'h1;
    @(posedge clock);
    direct_access <= 1'h0;
    // nine steps: eight counted, the last one only moves the levels
    for (int s = 0; s < 9; s++) begin
      @(posedge clock);
      step <= 1'h1;
      @(posedge clock);
      step <= 1'h0;
      repeat (9) begin
        @(negedge clock);
        if (s < 8 && sensor_event === 1'h1) n++;
      end
    end
    chk(mode, r.m);
    chk(phase_comparator_on, r.p);
    chk(pin_b, r.b);
    chk(port_read_enable, r.r);
    chk(port_pin_level, {motor_input_c, motor_input_b, motor_input_a} & r.r);
    if (r.e != 8'hff) chk(8'(n), r.e);
  endtask

  task automatic close_out;
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ********
  // sequence
  // ********
  initial begin
    repeat (7) @(posedge clock);
    @(negedge clock);
    chk(mode, 8'h01);
    chk(input_select_active, 8'h00);
    @(posedge clock);
    resetn <= 1'h1;
    foreach (rows[i]) run_row(rows[i]);
    chk(encoder_direction, 8'h01);
    reverse <= 1'h1;
    run_row(rows[8]);
    chk(encoder_direction, 8'h00);
    // select write without a load must wait for commutation
    @(posedge clock);
    cfg.input_select <= 2'h1;
    repeat (3) @(negedge clock);
    chk(input_select_active, 8'h03);
    @(posedge clock);
    commutation_event <= 1'h1;
    @(posedge clock);
    commutation_event <= 1'h0;
    @(negedge clock);
    chk(input_select_active, 8'h01);
    @(posedge clock);
    clock_enable <= 1'h0;
    direct_access <= 1'h1;
    cfg.input_select <= 2'h2;
    repeat (3) @(negedge clock);
    chk(input_select_active, 8'h01);
    @(posedge clock);
    clock_enable <= 1'h1;
    @(posedge clock);
    direct_access <= 1'h0;
    @(negedge clock);
    chk(input_select_active, 8'h02);
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out;
  end
endmodule // mist_input_stage_test
`default_nettype wire
